// ==== hdl/dtc_pkg.sv ====
`default_nettype none
package dtc_pkg;
    // Primary and extended operation codes
    localparam logic [5:0] DTC_OPC_REG      = 6'h1F;
    localparam logic [5:0] DTC_OPC_IMM      = 6'h02;
    localparam logic [9:0] DTC_XO_TRAP_DW   = 10'h044;
    // Instruction field positions (bit 0 is the instruction lsb)
    localparam int DTC_OPC_LSB  = 26;
    localparam int DTC_MASK_LSB = 21;
    localparam int DTC_RA_LSB   = 16;
    localparam int DTC_RB_LSB   = 11;
    localparam int DTC_XO_LSB   = 1;
    localparam int DTC_IMM_W    = 16;
    // Condition mask bit positions
    localparam int DTC_C_SLT = 4;
    localparam int DTC_C_SGT = 3;
    localparam int DTC_C_EQ  = 2;
    localparam int DTC_C_ULT = 1;
    localparam int DTC_C_UGT = 0;
    localparam int DTC_NUM_COND = 5;
    // Values after reset
    localparam logic       DTC_FLAG_RST = 1'h0;
    localparam logic [4:0] DTC_IDX_RST  = 5'h00;
endpackage
`default_nettype wire

// ==== hdl/dtc_compare.sv ====
`default_nettype none
module dtc_compare
    import dtc_pkg::*;
#(
    parameter int XLEN = 64
)(
    // Operands
    input  wire logic [XLEN-1:0]         op_a_i,
    input  wire logic [XLEN-1:0]         op_b_i,
    // Outcomes, indexed by mask position
    output logic      [DTC_NUM_COND-1:0] cond_o
);
    always_comb
    begin
        cond_o            = '0;
        cond_o[DTC_C_SLT] = $signed(op_a_i) < $signed(op_b_i);
        cond_o[DTC_C_SGT] = $signed(op_a_i) > $signed(op_b_i);
        cond_o[DTC_C_EQ]  = op_a_i == op_b_i;
        cond_o[DTC_C_ULT] = op_a_i < op_b_i;
        cond_o[DTC_C_UGT] = op_a_i > op_b_i;
    end
endmodule
`default_nettype wire

// ==== hdl/dtc_doubleword_trap_check.sv ====
`default_nettype none
module dtc_doubleword_trap_check
    import dtc_pkg::*;
#(
    parameter int  XLEN    = 64,
    parameter bit  IS_64   = 1'b1
)(
    // Clock and reset
    input  wire logic            sys_clk_i,
    input  wire logic            rst_b_i,
    // Issue
    input  wire logic            issue_valid_i,
    input  wire logic [31:0]     instr_i,
    input  wire logic [XLEN-1:0] first_source_reg_i,
    input  wire logic [XLEN-1:0] second_source_reg_i,
    // Decode view to register file
    output logic      [4:0]      first_source_idx_o,
    output logic      [4:0]      second_source_idx_o,
    // Results
    output logic                 trap_o,
    output logic                 illegal_o,
    output logic                 done_o
);
    // ********************************
    // Decode
    // ********************************
    logic                    is_reg;
    logic                    is_imm;
    logic                    is_trap;
    logic [4:0]              trap_condition_mask;
    logic [DTC_IMM_W-1:0]    signed_immediate;
    logic [XLEN-1:0]         imm_ext;
    logic [XLEN-1:0]         op_b;
    logic [DTC_NUM_COND-1:0] cond;
    logic [DTC_NUM_COND-1:0] sel;
    logic                    hit;

    // ********************************
    // Result registers
    // ********************************
    logic                    done_q;
    logic                    done_d;
    logic                    illegal_q;
    logic                    illegal_d;
    logic                    trap_q;
    logic                    trap_d;
    logic [4:0]              first_idx_q;
    logic [4:0]              first_idx_d;
    logic [4:0]              second_idx_q;
    logic [4:0]              second_idx_d;

    // Register form also checks extended opcode and a clear record bit
    assign is_reg = (instr_i[31:DTC_OPC_LSB] == DTC_OPC_REG)
                 && (instr_i[10:DTC_XO_LSB] == DTC_XO_TRAP_DW)
                 && !instr_i[0];
    assign is_imm = (instr_i[31:DTC_OPC_LSB] == DTC_OPC_IMM);

    // Anything else on the issue port is left to other units
    assign is_trap = issue_valid_i && (is_reg || is_imm);

    // Fixed fields, same place in both forms
    assign trap_condition_mask = instr_i[25:DTC_MASK_LSB];
    assign signed_immediate    = instr_i[DTC_IMM_W-1:0];

    // ********************************
    // Operand select
    // ********************************
    // Sign bit replicated so negative immediates compare as negative
    assign imm_ext = {{(XLEN-DTC_IMM_W){signed_immediate[DTC_IMM_W-1]}},
                      signed_immediate};
    // Immediate form never looks at the second register value
    assign op_b = is_imm ? imm_ext : second_source_reg_i;

    // ********************************
    // Compare
    // ********************************
    // All five outcomes at once; the mask decides which ones count
    dtc_compare #(
        .XLEN   (XLEN)
    ) i_dtc_compare (
        .op_a_i (first_source_reg_i),
        .op_b_i (op_b),
        .cond_o (cond)
    );

    // ********************************
    // Condition mask
    // ********************************
    // Field msb (instruction bit 25) selects signed less-than
    generate
        for (genvar g = 0; g < DTC_NUM_COND; g++)
        begin : g_mask
            assign sel[g] = trap_condition_mask[g] & cond[g];
        end
    endgenerate

    assign hit = |sel;

    // ********************************
    // Next values
    // ********************************
    // Recognised instruction, whatever the outcome
    always_comb
    begin
        done_d = is_trap;
    end

    // Narrow cores flag every recognised instruction illegal and ignore the compare outcome
    always_comb
    begin
        illegal_d = is_trap && !IS_64;
    end

    // Trap only on wide cores and only for a selected outcome
    always_comb
    begin
        trap_d = is_trap && IS_64 && hit;
    end

    // Index copies follow the word every cycle, valid or not
    always_comb
    begin
        first_idx_d = instr_i[20:DTC_RA_LSB];
    end

    // In the immediate form this is immediate bits, not an index
    always_comb
    begin
        second_idx_d = instr_i[15:DTC_RB_LSB];
    end

    // ********************************
    // Result flops
    // ********************************
    // Completion pulse
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            done_q <= DTC_FLAG_RST;
        end
        else
        begin
            done_q <= done_d;
        end
    end

    // Illegal-instruction pulse
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            illegal_q <= DTC_FLAG_RST;
        end
        else
        begin
            illegal_q <= illegal_d;
        end
    end

    // Trap pulse
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            trap_q <= DTC_FLAG_RST;
        end
        else
        begin
            trap_q <= trap_d;
        end
    end

    // First source index
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            first_idx_q <= DTC_IDX_RST;
        end
        else
        begin
            first_idx_q <= first_idx_d;
        end
    end

    // Second source index
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            second_idx_q <= DTC_IDX_RST;
        end
        else
        begin
            second_idx_q <= second_idx_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // Straight from the flops, no logic after them
    assign done_o              = done_q;
    assign illegal_o           = illegal_q;
    assign trap_o              = trap_q;
    assign first_source_idx_o  = first_idx_q;
    assign second_source_idx_o = second_idx_q;
endmodule
`default_nettype wire

// ==== testbench/dtc_trap_checker.sv ====
`default_nettype none
module dtc_trap_checker
    import dtc_pkg::*;
#(
    parameter int XLEN  = 64,
    parameter bit IS_64 = 1'b1
)(
    // ********
    // Watched ports
    // ********
    input wire logic            sys_clk_i,
    input wire logic            rst_b_i,
    input wire logic            issue_valid_i,
    input wire logic [31:0]     instr_i,
    input wire logic [XLEN-1:0] first_source_reg_i,
    input wire logic [XLEN-1:0] second_source_reg_i,
    input wire logic [4:0]      first_source_idx_o,
    input wire logic [4:0]      second_source_idx_o,
    input wire logic            trap_o,
    input wire logic            illegal_o,
    input wire logic            done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic [4:0]      m   = instr_i[25:21];
    wire logic            im  = issue_valid_i && instr_i[31:26] == DTC_OPC_IMM;
    wire logic            h   = im || issue_valid_i && instr_i[31:26] == DTC_OPC_REG
                                && instr_i[10:1] == DTC_XO_TRAP_DW && !instr_i[0];
    wire logic [XLEN-1:0] sx  = {{(XLEN-16){instr_i[15]}}, instr_i[15:0]};
    wire logic [XLEN-1:0] y   = im ? sx : second_source_reg_i;
    wire logic            slt = $signed(first_source_reg_i) < $signed(y);
    wire logic            sgt = $signed(first_source_reg_i) > $signed(y);
    wire logic            eq  = first_source_reg_i == y;
    wire logic            ult = first_source_reg_i < y;
    wire logic            ugt = first_source_reg_i > y;
    wire logic            want = m[4] && slt || m[3] && sgt || m[2] && eq
                                 || m[1] && ult || m[0] && ugt;
    sequence s_taken;
        h ##1 done_o;
    endsequence
    a_hit_done: assert property (h |-> s_taken) else $error("done missing");
    a_quiet_miss: assert property (!h |=> !done_o && !trap_o && !illegal_o)
        else $error("stray");
    a_idx_follow: assert property (1 |=> first_source_idx_o == $past(instr_i[20:16])
        && second_source_idx_o == $past(instr_i[15:11])) else $error("idx");
    a_eq_trap: assert property (IS_64 && h && m[2] && eq |=> trap_o)
        else $error("eq");
    a_imm_sext: assert property (IS_64 && im && m[4]
        && $signed(first_source_reg_i) < $signed(sx) |=> trap_o) else $error("imm");
    a_slt_trap: assert property (IS_64 && h && m[4] && slt |=> trap_o)
        else $error("slt");
    a_sgt_trap: assert property (IS_64 && h && m[3] && sgt |=> trap_o)
        else $error("sgt");
    a_ult_trap: assert property (IS_64 && h && m[1] && ult |=> trap_o)
        else $error("ult");
    a_ugt_trap: assert property (IS_64 && h && m[0] && ugt |=> trap_o)
        else $error("ugt");
    a_trap_exact: assert property (h |=> trap_o == (IS_64 && $past(want)))
        else $error("trap value");
    a_no_mask: assert property (h && m == 5'h00 |=> !trap_o) else $error("mask");
    a_narrow_ill: assert property (h |=> illegal_o == !IS_64) else $error("ill");
endmodule
bind dtc_doubleword_trap_check dtc_trap_checker #(.XLEN(XLEN), .IS_64(IS_64)) i_dtc_trap_checker
    (.sys_clk_i, .rst_b_i, .issue_valid_i, .instr_i, .first_source_reg_i,
     .second_source_reg_i, .first_source_idx_o, .second_source_idx_o, .trap_o, .illegal_o,
     .done_o);
`default_nettype wire

// ==== testbench/tb_dtc_doubleword_trap_check.sv ====
`default_nettype none
module tb_dtc_doubleword_trap_check
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_i = 1'b0, rst_b_i = 1'b0, issue_valid_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [63:0] first_source_reg_i = 64'h0, second_source_reg_i = 64'h0;
    logic [4:0]  first_source_idx_o;
    logic        trap_o, illegal_o, done_o;
    logic [4:0]  second_source_idx_o;
    logic        narrow_trap, narrow_ill, narrow_done;
    int          err_total = 0, checks_done = 0, cyc = 0;
    dtc_doubleword_trap_check i_dtc_doubleword_trap_check (.sys_clk_i, .rst_b_i, .issue_valid_i,
        .instr_i, .first_source_reg_i, .second_source_reg_i, .first_source_idx_o,
        .second_source_idx_o, .trap_o, .illegal_o, .done_o);
    dtc_doubleword_trap_check #(.IS_64(1'b0)) i_dtc_doubleword_trap_check_narrow (.sys_clk_i,
        .rst_b_i, .issue_valid_i, .instr_i, .first_source_reg_i, .second_source_reg_i,
        .first_source_idx_o(), .second_source_idx_o(), .trap_o(narrow_trap),
        .illegal_o(narrow_ill), .done_o(narrow_done));
    always #20 sys_clk_i = ~sys_clk_i;
    task automatic chk(string n, logic s, logic e);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s exp %b got %b", n, e, s);
        end
    endtask
    function automatic logic [31:0] f_reg(logic [4:0] m);
        return {DTC_OPC_REG, m, 5'h03, 5'h04, DTC_XO_TRAP_DW, 1'b0};
    endfunction
    task automatic run(logic [31:0] i, logic [63:0] a, b, logic t, d);
        @(posedge sys_clk_i);
        issue_valid_i <= 1'b1;
        instr_i <= i;
        first_source_reg_i <= a;
        second_source_reg_i <= b;
        @(posedge sys_clk_i);
        issue_valid_i <= 1'b0;
        #1;
        chk("trap", trap_o, t);
        chk("done", done_o, d);
        chk("ill", illegal_o, 1'b0);
        chk("idx", first_source_idx_o === 5'h03, 1'b1);
        chk("idx2", second_source_idx_o === i[15:11], 1'b1);
        chk("narrow trap", narrow_trap, 1'b0);
        chk("narrow ill", narrow_ill, d);
        chk("narrow done", narrow_done, d);
    endtask
    task automatic t_cond();
        for (int k = 0; k < 5; k++)
        begin
            run(f_reg(5'h1 << k), {64{1'b1}}, 64'h1, k == 4 || k == 0, 1'b1);
            run(f_reg(5'h1 << k), 64'h7, 64'h7, k == 2, 1'b1);
            run({DTC_OPC_IMM, 5'h1 << k, 5'h03, 16'hFFFE}, ~64'h1, 64'h0, k == 2, 1'b1);
            run({DTC_OPC_IMM, 5'h1 << k, 5'h03, 16'h8000}, 64'h5, 64'h0, k == 3 || k == 1,
                1'b1);
        end
        $display("t_cond done");
    endtask
    task automatic t_none();
        run(f_reg(5'h00), 64'h7, 64'h7, 1'b0, 1'b1);
        run(f_reg(5'h1F) | 32'h1, 64'h7, 64'h7, 1'b0, 1'b0);
        run({6'h3F, 5'h1F, 5'h03, 16'h0}, 64'h7, 64'h7, 1'b0, 1'b0);
        $display("t_none done");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 500)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_cond();
        t_none();
        final_report();
    end
endmodule
`default_nettype wire
